// *** logic/dram_train_regs.svh ***
// mode register addresses, command codes, field positions and reset values
`ifndef DRAM_TRAIN_REGS_SVH
`define DRAM_TRAIN_REGS_SVH

// first-edge command codes on ca[4:0]
`define CA_MPC          5'h00
`define CA_CAS2         5'h12
`define CA_READ         5'h02
`define CA_MRW1         5'h06
`define CA_MRW2         5'h16

// multipurpose operand codes
`define OP_RD_CAL       7'h43
`define OP_WR_FIFO      7'h47
`define OP_RD_FIFO      7'h41

// mode register addresses
`define MR_PAT_FIRST    6'h20
`define MR_PAT_SECOND   6'h28
`define MR_MASK_BYTE0   6'h0f
`define MR_MASK_BYTE1   6'h14
`define MR_MASK_CFG     6'h0d
`define MR_INV_CFG      6'h03

// reset values
`define RST_PAT_FIRST   8'h5a
`define RST_PAT_SECOND  8'h3c
`define RST_MASK_BYTE   8'h55
`define RST_MASK_CFG    8'h00
`define RST_INV_CFG     8'h00

// field positions
`define DM_DIS_BIT      5
`define WR_INV_BIT      7
`define RD_INV_BIT      6

// burst and storage shape
`define BURST_BEATS     16
`define LAST_BEAT       4'hf
`define FIFO_DEPTH      5
`define LANES           18

`endif

// *** logic/dram_train_pkg.sv ***
// types shared by the training logic
package dram_train_pkg;
    typedef enum {ST_IDLE, ST_SECOND} cmd_state_t;
    typedef enum {TRN_NONE, TRN_CAL, TRN_FIFO_RD, TRN_FIFO_WR} train_op_t;
endpackage : dram_train_pkg

// *** logic/pin_sync.sv ***
// two-flop synchroniser for a bundle of pin inputs
`timescale 1ns/1ps
module pin_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             clk_in,
    input  wire logic             rst_in,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_reg;

    // first stage feeds only the second stage
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            meta_reg <= '0;
            sync_out <= '0;
        end else begin
            meta_reg <= async_in;
            sync_out <= meta_reg;
        end
    end
endmodule : pin_sync

// *** logic/training_fifo.sv ***
// five-entry training store with independent write and read pointers
`timescale 1ns/1ps
`include "dram_train_regs.svh"
module training_fifo #(
    parameter int DEPTH = `FIFO_DEPTH,
    parameter int WIDTH = `LANES * `BURST_BEATS
) (
    input  wire logic             clk_in,
    input  wire logic             rst_in,
    input  wire logic             ptr_rst_in,
    input  wire logic             wr_adv_in,
    input  wire logic             rd_adv_in,
    input  wire logic             wr_en_in,
    input  wire logic [2:0]       wr_slot_in,
    input  wire logic [WIDTH-1:0] wr_data_in,
    input  wire logic [2:0]       rd_slot_in,
    output logic      [2:0]       wr_ptr_out,
    output logic      [2:0]       rd_ptr_out,
    output logic      [WIDTH-1:0] rd_data_out
);
    logic [WIDTH-1:0] mem_reg [DEPTH];

    if (DEPTH < 2 || DEPTH > 8) begin : g_depth_check
        $error("training_fifo: DEPTH must be 2 to 8");
    end

    function automatic logic [2:0] ptr_inc(input logic [2:0] p);
        return (p == 3'(DEPTH - 1)) ? 3'h0 : p + 3'h1;
    endfunction : ptr_inc

    // modulo-depth pointers, cleared on reset and power-down entry
    always_ff @(posedge clk_in) begin
        if (ptr_rst_in) begin
            wr_ptr_out <= 3'h0;
            rd_ptr_out <= 3'h0;
        end else begin
            if (wr_adv_in)
                wr_ptr_out <= ptr_inc(wr_ptr_out);
            if (rd_adv_in)
                rd_ptr_out <= ptr_inc(rd_ptr_out);
        end
    end

    // reads never touch storage; only reset and a completed write burst do
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            for (int i = 0; i < DEPTH; i++)
                mem_reg[i] <= '0;
        end else if (wr_en_in) begin
            mem_reg[wr_slot_in] <= wr_data_in;
        end
    end

    assign rd_data_out = mem_reg[rd_slot_in];

    a_ptr_cleared: assert property (@(posedge clk_in)
        ptr_rst_in |=> (wr_ptr_out == 3'h0 && rd_ptr_out == 3'h0))
        else $error("pointers not cleared");
    a_ptr_wraps: assert property (@(posedge clk_in)
        disable iff (rst_in)
        (rd_adv_in && !ptr_rst_in && rd_ptr_out == 3'(DEPTH - 1))
        |=> rd_ptr_out == 3'h0)
        else $error("read pointer did not wrap");
    a_read_keeps: assert property (@(posedge clk_in)
        disable iff (rst_in)
        (!wr_en_in ##1 $stable(rd_slot_in)) |-> $stable(rd_data_out))
        else $error("stored entry changed without a write");
endmodule : training_fifo

// *** logic/dram_dq_training_fifo.sv ***
// read calibration pattern and write-training store of one dram channel
`timescale 1ns/1ps
`include "dram_train_regs.svh"
module dram_dq_training_fifo
    import dram_train_pkg::*;
#(
    parameter int READ_LATENCY  = 6,
    parameter int WRITE_LATENCY = 4
) (
    input  wire logic        clk_in,
    input  wire logic        rst_in,
    input  wire logic        ck_in,
    input  wire logic        cke_in,
    input  wire logic        reset_n_in,
    input  wire logic        cs_in,
    input  wire logic [5:0]  ca_in,
    input  wire logic [15:0] dq_in,
    input  wire logic [1:0]  dmi_in,
    output logic      [15:0] dq_out,
    output logic             dq_oe_out,
    output logic      [1:0]  dmi_out,
    output logic             dmi_oe_out,
    output logic             dqs_out,
    output logic             dqs_oe_out
);
    localparam int SW = 28;
    localparam int EW = 5;
    localparam int FW = `LANES * `BURST_BEATS;

    if (READ_LATENCY < 2 || WRITE_LATENCY < 2) begin : g_latency_check
        $error("latencies below two ck cycles are not served");
    end

    // pins through two flops; ck edges found by the local clock
    logic [SW-1:0] pins_s;
    pin_sync #(.WIDTH(SW)) u_sync (
        .clk_in   (clk_in),
        .rst_in   (rst_in),
        .async_in ({ck_in, cke_in, reset_n_in, cs_in, ca_in, dmi_in, dq_in}),
        .sync_out (pins_s)
    );
    wire        ck_s     = pins_s[27];
    wire        cke_s    = pins_s[26];
    wire        rstn_s   = pins_s[25];
    wire        cs_s     = pins_s[24];
    wire [5:0]  ca_s     = pins_s[23:18];
    wire [17:0] lanes_s  = pins_s[17:0];

    logic ck_d_reg;
    logic cke_d_reg;
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            ck_d_reg  <= 1'b0;
            cke_d_reg <= 1'b0;
        end else begin
            ck_d_reg  <= ck_s;
            cke_d_reg <= cke_s;
        end
    end
    wire ck_rise = ck_s & ~ck_d_reg;
    wire ck_edge = ck_s ^ ck_d_reg;
    wire cke_fall = ~cke_s & cke_d_reg;
    wire ptr_rst = rst_in | ~rstn_s | cke_fall;

    // two-edge command capture
    function automatic logic is_code(input logic [5:0] ca,
                                     input logic [4:0] code);
        return ca[4:0] == code;
    endfunction : is_code

    cmd_state_t state_reg;
    cmd_state_t state_next;
    logic [5:0] first_reg;
    wire take_first  = ck_rise && cke_s && cs_s && state_reg == ST_IDLE;
    wire take_second = ck_rise && state_reg == ST_SECOND;

    always_comb begin
        case (state_reg)
            ST_IDLE:   state_next = take_first ? ST_SECOND : ST_IDLE;
            ST_SECOND: state_next = take_second ? ST_IDLE : ST_SECOND;
            default:   state_next = ST_IDLE;
        endcase
    end

    always_ff @(posedge clk_in) begin
        if (ptr_rst) begin
            state_reg <= ST_IDLE;
            first_reg <= 6'h00;
        end else begin
            state_reg <= state_next;
            if (take_first)
                first_reg <= ca_s;
        end
    end

    wire       is_mpc  = take_second && is_code(first_reg, `CA_MPC);
    wire       is_cas2 = take_second && is_code(first_reg, `CA_CAS2);
    wire       is_read = take_second && is_code(first_reg, `CA_READ);
    wire       is_mrw1 = take_second && is_code(first_reg, `CA_MRW1);
    wire       is_mrw2 = take_second && is_code(first_reg, `CA_MRW2);
    wire [6:0] mpc_op  = {first_reg[5], ca_s};

    // a training op stays armed only until the very next command
    train_op_t armed_reg;
    train_op_t armed_next;
    always_comb begin
        armed_next = armed_reg;
        if (take_second) begin
            armed_next = TRN_NONE;
            if (is_mpc) begin
                case (mpc_op)
                    `OP_RD_CAL:  armed_next = TRN_CAL;
                    `OP_WR_FIFO: armed_next = TRN_FIFO_WR;
                    `OP_RD_FIFO: armed_next = TRN_FIFO_RD;
                    default:     armed_next = TRN_NONE;
                endcase
            end
        end
    end

    always_ff @(posedge clk_in) begin
        if (ptr_rst)
            armed_reg <= TRN_NONE;
        else
            armed_reg <= armed_next;
    end

    wire launch_cal = is_cas2 && armed_reg == TRN_CAL;
    wire launch_frd = is_cas2 && armed_reg == TRN_FIFO_RD;
    wire launch_fwr = is_cas2 && armed_reg == TRN_FIFO_WR;
    wire launch_rd  = launch_cal | launch_frd;

    // mode registers written by the two-part write command
    logic [5:0] mrw_addr_reg;
    logic       mrw_op7_reg;
    logic [7:0] pat_first_reg;
    logic [7:0] pat_second_reg;
    logic [7:0] mask0_reg;
    logic [7:0] mask1_reg;
    logic [7:0] mask_cfg_reg;
    logic [7:0] inv_cfg_reg;
    wire  [7:0] mr_data = {mrw_op7_reg, first_reg[5], ca_s};

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            mrw_addr_reg   <= 6'h00;
            mrw_op7_reg    <= 1'b0;
            pat_first_reg  <= `RST_PAT_FIRST;
            pat_second_reg <= `RST_PAT_SECOND;
            mask0_reg      <= `RST_MASK_BYTE;
            mask1_reg      <= `RST_MASK_BYTE;
            mask_cfg_reg   <= `RST_MASK_CFG;
            inv_cfg_reg    <= `RST_INV_CFG;
        end else if (is_mrw1) begin
            mrw_addr_reg <= ca_s;
            mrw_op7_reg  <= first_reg[5];
        end else if (is_mrw2) begin
            case (mrw_addr_reg)
                `MR_PAT_FIRST:  pat_first_reg  <= mr_data;
                `MR_PAT_SECOND: pat_second_reg <= mr_data;
                `MR_MASK_BYTE0: mask0_reg      <= mr_data;
                `MR_MASK_BYTE1: mask1_reg      <= mr_data;
                `MR_MASK_CFG:   mask_cfg_reg   <= mr_data;
                `MR_INV_CFG:    inv_cfg_reg    <= mr_data;
                default:        mask0_reg      <= mask0_reg;
            endcase
        end
    end

    // dmi floats only with masking and both inversions off
    wire dmi_enable = ~mask_cfg_reg[`DM_DIS_BIT] | inv_cfg_reg[`WR_INV_BIT]
                    | inv_cfg_reg[`RD_INV_BIT];

    // training fifo and its pointers
    logic [2:0]    wr_ptr;
    logic [2:0]    rd_ptr;
    logic [FW-1:0] fifo_rd_data;
    logic [FW-1:0] cap_reg;
    logic [FW-1:0] cap_next;
    logic          fifo_wr_en;
    logic [2:0]    cap_slot;
    logic [2:0]    drive_slot;

    training_fifo #(.DEPTH(`FIFO_DEPTH), .WIDTH(FW)) u_fifo (
        .clk_in      (clk_in),
        .rst_in      (rst_in),
        .ptr_rst_in  (ptr_rst),
        .wr_adv_in   (launch_fwr | is_read),
        .rd_adv_in   (launch_frd | is_read),
        .wr_en_in    (fifo_wr_en),
        .wr_slot_in  (cap_slot),
        .wr_data_in  (cap_next),
        .rd_slot_in  (drive_slot),
        .wr_ptr_out  (wr_ptr),
        .rd_ptr_out  (rd_ptr),
        .rd_data_out (fifo_rd_data)
    );

    // latency lines step on ck rising edges: {valid, fifo, slot}
    logic [EW*READ_LATENCY-1:0]  rd_line_reg;
    logic [EW*WRITE_LATENCY-1:0] wr_line_reg;
    wire  [EW-1:0] rd_entry = {launch_rd, launch_frd, rd_ptr};
    wire  [EW-1:0] wr_entry = {launch_fwr, 1'b1, wr_ptr};
    wire  [EW-1:0] rd_due = rd_line_reg[EW*READ_LATENCY-1 -: EW];
    wire  [EW-1:0] wr_due = wr_line_reg[EW*WRITE_LATENCY-1 -: EW];

    always_ff @(posedge clk_in) begin
        if (ptr_rst) begin
            rd_line_reg <= '0;
            wr_line_reg <= '0;
        end else if (ck_rise) begin
            rd_line_reg <= {rd_line_reg[EW*READ_LATENCY-EW-1:0], rd_entry};
            wr_line_reg <= {wr_line_reg[EW*WRITE_LATENCY-EW-1:0], wr_entry};
        end
    end

    // read burst: one beat per ck edge, a new start overrides the tail
    logic       rd_busy_reg;
    logic [3:0] rd_beat_reg;
    logic       rd_fifo_reg;
    logic [2:0] rd_slot_reg;
    wire        rd_start   = ck_rise && rd_due[4];
    wire        rd_step    = ck_edge && rd_busy_reg;
    wire        drive_now  = rd_start | (rd_step && rd_beat_reg != `LAST_BEAT);
    wire  [3:0] drive_beat = rd_start ? 4'h0 : rd_beat_reg + 4'h1;
    wire        drive_fifo = rd_start ? rd_due[3] : rd_fifo_reg;
    assign      drive_slot = rd_start ? rd_due[2:0] : rd_slot_reg;

    always_ff @(posedge clk_in) begin
        if (ptr_rst) begin
            rd_busy_reg <= 1'b0;
            rd_beat_reg <= 4'h0;
            rd_fifo_reg <= 1'b0;
            rd_slot_reg <= 3'h0;
        end else begin
            rd_busy_reg <= drive_now | (rd_busy_reg & ~rd_step);
            if (drive_now) begin
                rd_beat_reg <= drive_beat;
                rd_fifo_reg <= drive_fifo;
                rd_slot_reg <= drive_slot;
            end
        end
    end

    // lane data for the current beat
    wire [15:0] cal_pattern = {pat_second_reg, pat_first_reg};
    wire        cal_bit     = cal_pattern[drive_beat];
    wire [15:0] dq_cal = {16{cal_bit}} ^ {mask1_reg, mask0_reg};
    logic [17:0] fifo_lanes;
    for (genvar p = 0; p < `LANES; p++) begin : g_lane
        assign fifo_lanes[p] = fifo_rd_data[p*`BURST_BEATS + int'(drive_beat)];
    end
    wire [15:0] dq_bits  = drive_fifo ? fifo_lanes[15:0] : dq_cal;
    wire [1:0]  dmi_bits = drive_fifo ? fifo_lanes[17:16] : {2{cal_bit}};

    always_ff @(posedge clk_in) begin
        if (ptr_rst) begin
            dq_out     <= 16'h0000;
            dq_oe_out  <= 1'b0;
            dmi_out    <= 2'h0;
            dmi_oe_out <= 1'b0;
            dqs_out    <= 1'b0;
            dqs_oe_out <= 1'b0;
        end else if (drive_now) begin
            dq_out     <= dq_bits;
            dq_oe_out  <= 1'b1;
            dmi_out    <= dmi_bits;
            dmi_oe_out <= dmi_enable;
            dqs_out    <= ~drive_beat[0];
            dqs_oe_out <= 1'b1;
        end else if (rd_step) begin
            dq_oe_out  <= 1'b0;
            dmi_oe_out <= 1'b0;
            dqs_oe_out <= 1'b0;
            dqs_out    <= 1'b0;
        end
    end

    // write capture: lanes sampled on each ck edge of the burst
    logic       wr_busy_reg;
    logic [3:0] wr_beat_reg;
    logic [2:0] wr_slot_reg;
    wire        wr_start = ck_rise && wr_due[4];
    wire        wr_step  = ck_edge && wr_busy_reg;
    wire        cap_now  = wr_start | (wr_step && wr_beat_reg != `LAST_BEAT);
    wire  [3:0] cap_beat = wr_start ? 4'h0 : wr_beat_reg + 4'h1;
    assign      cap_slot = wr_start ? wr_due[2:0] : wr_slot_reg;
    assign      fifo_wr_en = cap_now && cap_beat == `LAST_BEAT;

    always_comb begin
        cap_next = cap_reg;
        for (int p = 0; p < `LANES; p++)
            cap_next[p*`BURST_BEATS + int'(cap_beat)] = lanes_s[p];
    end

    always_ff @(posedge clk_in) begin
        if (ptr_rst) begin
            wr_busy_reg <= 1'b0;
            wr_beat_reg <= 4'h0;
            wr_slot_reg <= 3'h0;
            cap_reg     <= '0;
        end else begin
            wr_busy_reg <= cap_now | (wr_busy_reg & ~wr_step);
            if (cap_now) begin
                wr_beat_reg <= cap_beat;
                wr_slot_reg <= cap_slot;
                cap_reg     <= cap_next;
            end
        end
    end

    // helpers watched only by the checks below
    logic       cal_q_reg;
    logic       cal_bit_q_reg;
    logic [3:0] beat_q_reg;
    logic [5:0] drives_reg;
    always_ff @(posedge clk_in) begin
        if (ptr_rst) begin
            cal_q_reg     <= 1'b0;
            cal_bit_q_reg <= 1'b0;
            beat_q_reg    <= 4'h0;
            drives_reg    <= 6'h00;
        end else begin
            if (drive_now) begin
                cal_q_reg     <= ~drive_fifo;
                cal_bit_q_reg <= cal_bit;
                beat_q_reg    <= drive_beat;
            end
            drives_reg <= drive_now ? drives_reg + 6'h01
                        : (dq_oe_out ? drives_reg : 6'h00);
        end
    end

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (ptr_rst);

    a_cke_gates_cmd: assert property (!cke_s |-> !take_first)
        else $error("command taken with cke low");
    a_nop_mpc: assert property ((is_mpc && !mpc_op[6]) |=>
        armed_reg == TRN_NONE)
        else $error("nop operand armed a training op");
    a_cal_masking: assert property ((dq_oe_out && cal_q_reg) |->
        dq_out == ({16{cal_bit_q_reg}} ^ {mask1_reg, mask0_reg}))
        else $error("calibration lane inversion wrong");
    a_dmi_plain: assert property ((dmi_oe_out && cal_q_reg) |->
        dmi_out == {2{cal_bit_q_reg}})
        else $error("dmi lane altered during calibration");
    a_dmi_float: assert property ((dq_oe_out && !dmi_enable) |->
        !dmi_oe_out)
        else $error("dmi driven with all functions disabled");
    a_lsb_first: assert property ((dq_oe_out && cal_q_reg &&
        beat_q_reg == 4'h0) |-> cal_bit_q_reg == pat_first_reg[0])
        else $error("pattern not sent low bit first");
    a_burst_whole: assert property ($fell(dq_oe_out) |->
        drives_reg[3:0] == 4'h0)
        else $error("burst not a multiple of sixteen beats");
    a_launch_line: assert property (launch_rd |=> rd_line_reg[EW-1])
        else $error("read launch not queued");
    a_fifo_write: assert property (fifo_wr_en |=>
        u_fifo.mem_reg[$past(cap_slot)] == $past(cap_next))
        else $error("write burst not stored");

    c_cal_burst: cover property (rd_start && !rd_due[3]);
    c_fifo_read: cover property (rd_start && rd_due[3]);
    c_fifo_write: cover property (fifo_wr_en);
    c_seamless: cover property (rd_start && rd_busy_reg);
endmodule : dram_dq_training_fifo

// *** tb/dram_ctrl_model.sv ***
// memory controller model: dram clock, command bus and write-data lanes
`timescale 1ns/1ps
`include "dram_train_regs.svh"
module dram_ctrl_model #(
    parameter int WRITE_LATENCY = 4
) (
    output logic        ck_out,
    output logic        cs_out,
    output logic [5:0]  ca_out,
    output logic [15:0] dq_out,
    output logic [1:0]  dmi_out
);
    realtime t_launch;
    // offset keeps ck edges away from the system clock edges
    initial begin
        ck_out = 1'b0;
        cs_out = 1'b0;
        ca_out = 6'h00;
        {dmi_out, dq_out} = 18'h0;
        #1;
        forever #62.5 ck_out = ~ck_out;
    end
    // bus set at ck fall, so each rise samples a settled value
    task automatic cmd(input logic [5:0] first, input logic [5:0] second);
        @(negedge ck_out);
        cs_out = 1'b1;
        ca_out = first;
        @(negedge ck_out);
        cs_out = 1'b0;
        ca_out = second;
        @(posedge ck_out);
        t_launch = $realtime;
    endtask : cmd
    task automatic train(input logic [6:0] op);
        cmd({op[6], `CA_MPC}, op[5:0]);
        cmd({1'b0, `CA_CAS2}, 6'h00);
        @(negedge ck_out);
        ca_out = ~ca_out; // released bus never shows the last value
    endtask : train
    task automatic mrw(input logic [5:0] adr, input logic [7:0] d);
        cmd({d[7], `CA_MRW1}, adr);
        cmd({d[6], `CA_MRW2}, d[5:0]);
        @(negedge ck_out);
        ca_out = ~ca_out;
    endtask : mrw
    // words change mid-way between ck edges for margin
    task automatic wr_burst(input logic [17:0] w [16]);
        train(`OP_WR_FIFO);
        repeat (WRITE_LATENCY - 1) @(posedge ck_out);
        @(negedge ck_out);
        #31;
        for (int k = 0; k < 16; k++) begin
            {dmi_out, dq_out} = w[k];
            @(ck_out);
            #31;
        end
        {dmi_out, dq_out} = ~w[15];
    endtask : wr_burst
endmodule : dram_ctrl_model

// *** tb/dram_dq_training_fifo_bench.sv ***
// self-checking bench for the dram training block
`timescale 1ns/1ps
`include "dram_train_regs.svh"
module dram_dq_training_fifo_bench;
    localparam int RL = 6;
    localparam int WL = 4;
    logic        clk_in, rst_in, cke_in, reset_n_in, ck, cs;
    logic [5:0]  ca;
    logic [15:0] dq_in, dq_out;
    logic [1:0]  dmi_in, dmi_out;
    logic        dq_oe_out, dmi_oe_out, dqs_out, dqs_oe_out, oe_d, dqs_d;
    logic [18:0] q [$];
    logic [17:0] mem [5][16];
    logic [15:0] rnd;
    logic [7:0]  pf, ps, m0, m1;
    int          rises, r0, err_total, cmp_count;
    realtime     t_rise;

    dram_dq_training_fifo #(.READ_LATENCY(RL), .WRITE_LATENCY(WL)) i_dut (
        .clk_in(clk_in), .rst_in(rst_in), .ck_in(ck), .cke_in(cke_in),
        .reset_n_in(reset_n_in), .cs_in(cs), .ca_in(ca), .dq_in(dq_in),
        .dmi_in(dmi_in), .dq_out(dq_out), .dq_oe_out(dq_oe_out),
        .dmi_out(dmi_out), .dmi_oe_out(dmi_oe_out), .dqs_out(dqs_out),
        .dqs_oe_out(dqs_oe_out));
    dram_ctrl_model #(.WRITE_LATENCY(WL)) i_ctrl (
        .ck_out(ck), .cs_out(cs), .ca_out(ca), .dq_out(dq_in),
        .dmi_out(dmi_in));

    initial begin
        clk_in = 1'b0;
        forever #5 clk_in = ~clk_in;
    end
    // a new beat shows as a strobe toggle while driving
    always @(posedge clk_in) begin
        if (dq_oe_out === 1'b1 && (oe_d !== 1'b1 || dqs_out !== dqs_d))
            q.push_back({dmi_oe_out, dmi_out, dq_out});
        if (dq_oe_out === 1'b1 && oe_d !== 1'b1) begin
            rises++;
            t_rise = $realtime;
            chk("strobe start", 19'h3, {17'h0, dqs_oe_out, dqs_out});
        end
        if (dq_oe_out === 1'b0 && oe_d === 1'b1)
            chk("strobe end", 19'h0, {17'h0, dqs_oe_out, dqs_out});
        oe_d <= dq_oe_out;
        dqs_d <= dqs_out;
    end

    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : lfsr
    function automatic logic [18:0] cal_beat(input int k, input logic on);
        logic [15:0] p;
        p = {ps, pf};
        return {on, on ? {2{p[k]}} : 2'b00, {m1, m0} ^ {16{p[k]}}};
    endfunction : cal_beat
    task automatic chk(input string what, input logic [18:0] exp,
                       input logic [18:0] got);
        cmp_count++;
        if (got !== exp) begin
            err_total++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic take(input string what, input logic [18:0] exp);
        logic [18:0] got;
        int          n;
        n = 0;
        got = 'x;
        while (q.size() == 0 && n < 3000) begin
            @(posedge clk_in);
            n++;
        end
        if (q.size() > 0) got = q.pop_front();
        if (got[18] === 1'b0) got[17:16] = 2'b00; // floating lanes unseen
        chk(what, exp, got);
    endtask : take
    task automatic lat_chk();
        realtime d;
        d = t_rise - i_ctrl.t_launch;
        chk("latency", 19'h1,
            {18'h0, d >= RL * 125.0 && d <= RL * 125.0 + 80.0});
    endtask : lat_chk
    task automatic cal_check(input logic on, input int n);
        for (int k = 0; k < n; k++) begin
            take("cal beat", cal_beat(k % 16, on));
            if (k == 0 && n == 16) lat_chk();
        end
    endtask : cal_check
    task automatic fifo_rd(input int e);
        i_ctrl.train(`OP_RD_FIFO);
        for (int k = 0; k < 16; k++) begin
            take("fifo beat", {1'b1, mem[e][k]});
            if (k == 0) lat_chk();
        end
    endtask : fifo_rd
    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : wrap_up

    initial begin
        #400000;
        err_total++;
        wrap_up();
    end
    initial begin
        rst_in = 1'b1;
        cke_in = 1'b1;
        reset_n_in = 1'b1;
        rnd = 16'h88cb;
        {pf, ps, m0, m1} = 32'h5a3c5555;
        repeat (12) @(posedge clk_in);
        @(negedge clk_in) rst_in = 1'b0;
        repeat (4) @(posedge ck);
        i_ctrl.train(`OP_RD_CAL);
        cal_check(1'b1, 16);
        // all eight dmi configurations, random pattern and masks
        for (int c = 0; c < 8; c++) begin
            rnd = lfsr(rnd);
            {ps, pf} = rnd;
            rnd = lfsr(rnd);
            {m1, m0} = rnd;
            i_ctrl.mrw(`MR_PAT_FIRST, pf);
            i_ctrl.mrw(`MR_PAT_SECOND, ps);
            i_ctrl.mrw(`MR_MASK_BYTE0, m0);
            i_ctrl.mrw(`MR_MASK_BYTE1, m1);
            i_ctrl.mrw(`MR_MASK_CFG, {2'b00, c[0], 5'h00});
            i_ctrl.mrw(`MR_INV_CFG, {c[2:1], 6'h00});
            r0 = rises;
            i_ctrl.train(`OP_RD_CAL);
            if (c == 7) begin
                repeat (4) @(posedge ck);
                i_ctrl.train(`OP_RD_CAL);
            end
            cal_check(c != 1, c == 7 ? 32 : 16);
        end
        chk("one window", 19'h1, 19'(rises - r0));
        r0 = rises;
        i_ctrl.train(7'h03);
        i_ctrl.train(7'h45);
        repeat (20) @(posedge ck);
        chk("nop bursts", 19'h0, 19'(rises - r0));
        for (int e = 0; e < 5; e++) begin
            for (int k = 0; k < 16; k++) begin
                rnd = lfsr(rnd);
                mem[e][k] = {rnd[2:1], rnd};
            end
            i_ctrl.wr_burst(mem[e]);
        end
        repeat (8) @(posedge ck);
        for (int r = 0; r < 10; r++) fifo_rd(r % 5);
        // a normal read moves both pointers off zero before each reset
        for (int i = 0; i < 2; i++) begin
            repeat (24) @(posedge ck); // gap after training reads
            i_ctrl.cmd({1'b0, `CA_READ}, 6'h00);
            i_ctrl.cmd({1'b0, `CA_CAS2}, 6'h00);
            repeat (24) @(posedge ck); // gap before power-down or reset entry
            @(negedge ck);
            if (i == 0) cke_in = 1'b0;
            else reset_n_in = 1'b0;
            repeat (3) @(negedge ck);
            cke_in = 1'b1;
            reset_n_in = 1'b1;
            repeat (3) @(posedge ck); // exit delay before training
            i_ctrl.train(`OP_RD_CAL);
            cal_check(1'b1, 16);
            fifo_rd(0);
        end
        repeat (24) @(posedge ck); // spacing before a normal read
        i_ctrl.cmd({1'b0, `CA_READ}, 6'h00); // after training only
        i_ctrl.cmd({1'b0, `CA_CAS2}, 6'h00);
        repeat (30) @(posedge ck);
        chk("normal read quiet", 19'h0, 19'(q.size()));
        fifo_rd(2);
        wrap_up();
    end
endmodule : dram_dq_training_fifo_bench
